/* File: rtl/ptp_event_defines.svh */
// Functional notes
// - writing one to a status flag clears it
// - enabled flags OR into summary event, chip status bit 29
// - enable bit one makes the event a source, zero removes it
// - flags set by events whatever the enables say
// - system interrupt needs summary event and chip enable bit 29
// - enables at 24:16, each sixteen above its flag at 8:0
// - port 2 receive capture sets bit 8, transmit sets bit 7
// - port 1 receive capture sets bit 6, transmit sets bit 5
// - fabric to host MAC capture sets bit 4
// - host MAC to fabric capture sets bit 3
// - pin b capture sets bit 2, pin a capture sets bit 1
// - capture pins edge detected, active over 40 ns; sampled every 100 ns, so a pulse shorter than 100 ns may be missed
// - clock reaching the 64-bit target sets bit 0
// - enabled capture pin edge also clears the target flag
// - pin a lock stops capture overwrite while its flag is set
// - pin event mode 10 drives the target flag onto the pin
`ifndef PTP_EVENT_DEFINES_SVH
`define PTP_EVENT_DEFINES_SVH
`define ADDR_STATUS_ENABLE 12'h198
`define ADDR_CHIP_STATUS   12'h19c
`define ADDR_CHIP_ENABLE   12'h1a0
`define ADDR_PIN_CONFIG    12'h1a4
`define NUM_EVENTS         9
`define EN_SHIFT           16
`define SUMMARY_BIT        29
`define FLAG_MASK          32'h0000_01ff
`define EN_MASK            32'h01ff_0000
`define FLAG_TIMER         0
`define FLAG_PIN_A         1
`define FLAG_PIN_B         2
`define CFG_LOCK_A         5
`define CFG_CLR_A          6
`define CFG_CLR_B          7
`define CFG_MODE_A_LO      1
`define CFG_MODE_B_LO      3
`define CFG_MASK           8'hfe
`define CLK_PERIOD_NS      100
`define PIN_MIN_ACTIVE_NS  40
`define PIN_MIN_CYCLES     ((`PIN_MIN_ACTIVE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* File: rtl/ptp_event_pkg.sv */
package ptp_event_pkg;
    typedef enum logic [1:0] {
        PIN_PULSE  = 2'b00,
        PIN_TOGGLE = 2'b01,
        PIN_LEVEL  = 2'b10,
        PIN_RSVD   = 2'b11
    } pin_mode_t;
    typedef enum logic [1:0] {
        APB_IDLE   = 2'b00,
        APB_SETUP  = 2'b01,
        APB_ACCESS = 2'b11
    } apb_state_t;
endpackage

/* File: rtl/pin_edge_detect.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ptp_event_defines.svh"
module pin_edge_detect (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rstn,
    // pin and event
    input  wire logic i_pin,
    output logic      o_rise
);
    logic       sync1_ff;
    logic       sync2_ff;
    logic       prev_ff;
    logic       nxt_sync1;
    logic       nxt_sync2;
    logic       nxt_prev;
    always_comb begin
        nxt_sync1 = i_pin;
        nxt_sync2 = sync1_ff;
        nxt_prev  = sync2_ff;
    end
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff  <= 1'b0;
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
            prev_ff  <= nxt_prev;
        end
    end
    // a pulse held over 40 ns spans at least one 100 ns sample edge only if longer; shorter may be missed
    assign o_rise = sync2_ff & ~prev_ff;
endmodule
`default_nettype wire

/* File: rtl/target_compare.sv */
`timescale 1ns/1ps
`default_nettype none
module target_compare (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    // clock and target
    input  wire logic [63:0] i_clock_value,
    input  wire logic [31:0] i_target_high_word,
    input  wire logic [31:0] i_target_low_word,
    output logic             o_reached
);
    logic       above_ff;
    logic       nxt_above;
    always_comb begin
        nxt_above = (i_clock_value >= {i_target_high_word, i_target_low_word});
    end
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            above_ff <= 1'b0;
        end else begin
            above_ff <= nxt_above;
        end
    end
    // event only on entering the reached state, so a cleared flag does not re-set forever
    assign o_reached = nxt_above & ~above_ff;
endmodule
`default_nettype wire

/* File: rtl/ptp_event_interrupt_status.sv */
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "ptp_event_defines.svh"
module ptp_event_interrupt_status
    import ptp_event_pkg::*;
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    // apb slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // capture events from same clock domain
    input  wire logic        i_p2_rx_capture,
    input  wire logic        i_p2_tx_capture,
    input  wire logic        i_p1_rx_capture,
    input  wire logic        i_p1_tx_capture,
    input  wire logic        i_host_rx_capture,
    input  wire logic        i_host_tx_capture,
    // capture pins
    input  wire logic        i_pin_a,
    input  wire logic        i_pin_b,
    // clock and target
    input  wire logic [63:0] i_clock_value,
    input  wire logic [31:0] i_target_high_word,
    input  wire logic [31:0] i_target_low_word,
    // results
    output logic             o_timestamp_summary_event,
    output logic             o_irq,
    output logic             o_pin_a_out,
    output logic             o_pin_b_out,
    output logic             o_pin_a_capture_load
);
    logic [8:0]  flags_ff;
    logic [8:0]  nxt_flags;
    logic [8:0]  enables_ff;
    logic [8:0]  nxt_enables;
    logic        chip_en_ff;
    logic        nxt_chip_en;
    logic [7:0]  cfg_ff;
    logic [7:0]  nxt_cfg;
    logic        summary_ff;
    logic        nxt_summary;
    logic        irq_ff;
    logic        nxt_irq;
    logic        pin_a_ff;
    logic        nxt_pin_a;
    logic        pin_b_ff;
    logic        nxt_pin_b;
    logic        load_ff;
    logic        nxt_load;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic        pready_ff;
    logic        nxt_pready;
    logic        pslverr_ff;
    logic        nxt_pslverr;
    logic        rise_a;
    logic        rise_b;
    logic        reached;
    logic [8:0]  set_vec;
    logic [8:0]  clr_vec;
    logic        wr_en;
    logic        rd_en;
    logic        addr_ok;
    pin_mode_t   mode_a;
    pin_mode_t   mode_b;

    pin_edge_detect u_edge_a (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_pin  (i_pin_a),
        .o_rise (rise_a)
    );
    pin_edge_detect u_edge_b (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_pin  (i_pin_b),
        .o_rise (rise_b)
    );
    target_compare u_cmp (
        .i_clk              (i_clk),
        .i_rstn             (i_rstn),
        .i_clock_value      (i_clock_value),
        .i_target_high_word (i_target_high_word),
        .i_target_low_word  (i_target_low_word),
        .o_reached          (reached)
    );

    assign addr_ok = (i_paddr == `ADDR_STATUS_ENABLE) || (i_paddr == `ADDR_CHIP_STATUS)
                   || (i_paddr == `ADDR_CHIP_ENABLE) || (i_paddr == `ADDR_PIN_CONFIG);
    // one-wait-state slave: answer in the second access cycle, registered
    assign wr_en   = i_psel & i_penable & i_pwrite & ~pready_ff;
    assign rd_en   = i_psel & i_penable & ~i_pwrite & ~pready_ff;
    assign mode_a  = pin_mode_t'(cfg_ff[`CFG_MODE_A_LO +: 2]);
    assign mode_b  = pin_mode_t'(cfg_ff[`CFG_MODE_B_LO +: 2]);

    always_comb begin
        set_vec = {i_p2_rx_capture, i_p2_tx_capture,
                   i_p1_rx_capture, i_p1_tx_capture,
                   i_host_rx_capture,
                   i_host_tx_capture,
                   rise_b, rise_a,
                   reached};
        clr_vec = 9'h000;
        if (wr_en && i_paddr == `ADDR_STATUS_ENABLE) begin
            clr_vec = i_pwdata[8:0];
        end
        if ((rise_a && cfg_ff[`CFG_CLR_A]) || (rise_b && cfg_ff[`CFG_CLR_B])) begin
            clr_vec[`FLAG_TIMER] = 1'b1;
        end
        // set wins over a clear in the same cycle
        nxt_flags = (flags_ff & ~clr_vec) | set_vec;
        nxt_enables = enables_ff;
        nxt_chip_en = chip_en_ff;
        nxt_cfg     = cfg_ff;
        if (wr_en && i_paddr == `ADDR_STATUS_ENABLE) begin
            nxt_enables = i_pwdata[`EN_SHIFT +: `NUM_EVENTS];
        end
        if (wr_en && i_paddr == `ADDR_CHIP_ENABLE) begin
            nxt_chip_en = i_pwdata[`SUMMARY_BIT];
        end
        if (wr_en && i_paddr == `ADDR_PIN_CONFIG) begin
            nxt_cfg = i_pwdata[7:0] & `CFG_MASK;
        end
        nxt_summary = |(flags_ff & enables_ff);
        nxt_irq     = nxt_summary & chip_en_ff;
        // lock holds the captured value while the earlier capture is unacknowledged
        nxt_load    = rise_a & ~(cfg_ff[`CFG_LOCK_A] & flags_ff[`FLAG_PIN_A]);
        nxt_pin_a   = pin_a_ff;
        nxt_pin_b   = pin_b_ff;
        case (mode_a)
            PIN_PULSE:  nxt_pin_a = reached;
            PIN_TOGGLE: nxt_pin_a = pin_a_ff ^ reached;
            PIN_LEVEL:  nxt_pin_a = nxt_flags[`FLAG_TIMER];
            default:    nxt_pin_a = 1'b0;
        endcase
        case (mode_b)
            PIN_PULSE:  nxt_pin_b = reached;
            PIN_TOGGLE: nxt_pin_b = pin_b_ff ^ reached;
            PIN_LEVEL:  nxt_pin_b = nxt_flags[`FLAG_TIMER];
            default:    nxt_pin_b = 1'b0;
        endcase
        nxt_pready  = i_psel & i_penable & ~pready_ff;
        nxt_pslverr = i_psel & i_penable & ~pready_ff & ~addr_ok;
        nxt_prdata  = 32'h0000_0000;
        if (rd_en) begin
            case (i_paddr)
                `ADDR_STATUS_ENABLE: nxt_prdata = {7'h00, enables_ff, 7'h00, flags_ff};
                `ADDR_CHIP_STATUS:   nxt_prdata = {2'h0, summary_ff, 29'h0000_0000};
                `ADDR_CHIP_ENABLE:   nxt_prdata = {2'h0, chip_en_ff, 29'h0000_0000};
                `ADDR_PIN_CONFIG:    nxt_prdata = {24'h00_0000, cfg_ff};
                default:             nxt_prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            flags_ff   <= 9'h000;
            enables_ff <= 9'h000;
            chip_en_ff <= 1'b0;
            cfg_ff     <= 8'h00;
            summary_ff <= 1'b0;
            irq_ff     <= 1'b0;
            pin_a_ff   <= 1'b0;
            pin_b_ff   <= 1'b0;
            load_ff    <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            flags_ff   <= nxt_flags;
            enables_ff <= nxt_enables;
            chip_en_ff <= nxt_chip_en;
            cfg_ff     <= nxt_cfg;
            summary_ff <= nxt_summary;
            irq_ff     <= nxt_irq;
            pin_a_ff   <= nxt_pin_a;
            pin_b_ff   <= nxt_pin_b;
            load_ff    <= nxt_load;
            prdata_ff  <= nxt_prdata;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    assign o_prdata                  = prdata_ff;
    assign o_pready                  = pready_ff;
    assign o_pslverr                 = pslverr_ff;
    assign o_timestamp_summary_event = summary_ff;
    assign o_irq                     = irq_ff;
    assign o_pin_a_out               = pin_a_ff;
    assign o_pin_b_out               = pin_b_ff;
    assign o_pin_a_capture_load      = load_ff;

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    AST_W1C_CLEARS: assert property (
        (wr_en && i_paddr == `ADDR_STATUS_ENABLE && i_pwdata[8] && !i_p2_rx_capture)
        |=> !flags_ff[8]) else $error("status flag not cleared by write one");
    AST_SUMMARY: assert property (
        (|(flags_ff & enables_ff)) |=> summary_ff) else $error("summary missing");
    AST_NO_SUMMARY: assert property (
        (enables_ff == 9'h000) |=> !summary_ff) else $error("summary without enables");
    AST_SET_ANY: assert property (
        i_p1_tx_capture |=> flags_ff[5]) else $error("flag not set by event");
    AST_IRQ_GATE: assert property (
        o_irq |-> $past(chip_en_ff)) else $error("irq without chip enable");
    AST_P2_RX: assert property (
        i_p2_rx_capture |=> flags_ff[8] && nxt_summary == (enables_ff[8] | nxt_summary))
        else $error("port 2 receive flag missing");
    AST_HOST_TX: assert property (
        i_host_tx_capture |=> flags_ff[3]) else $error("host transmit flag missing");
    AST_PIN_A: assert property (
        rise_a |=> flags_ff[`FLAG_PIN_A]) else $error("pin a flag missing");
    AST_TIMER_CLR: assert property (
        (rise_b && cfg_ff[`CFG_CLR_B] && !reached) |=> !flags_ff[`FLAG_TIMER])
        else $error("pin edge did not clear target flag");
    AST_LOCK: assert property (
        (cfg_ff[`CFG_LOCK_A] && flags_ff[`FLAG_PIN_A]) |=> !o_pin_a_capture_load)
        else $error("locked capture overwritten");
    AST_LEVEL: assert property (
        (mode_a == PIN_LEVEL) |=> o_pin_a_out == flags_ff[`FLAG_TIMER])
        else $error("pin level mode wrong");
    AST_READY_ONE: assert property (
        o_pready |=> !o_pready) else $error("pready held");

    // set checks for the remaining capture sources, then flag clear, keep and enable checks
    AST_P2_TX: assert property (
        i_p2_tx_capture |=> flags_ff[7])
        else $error("port 2 transmit flag missing");
    AST_P1_RX: assert property (
        i_p1_rx_capture |=> flags_ff[6])
        else $error("port 1 receive flag missing");
    AST_HOST_RX: assert property (
        i_host_rx_capture |=> flags_ff[4])
        else $error("host receive flag missing");
    AST_PIN_B: assert property (
        rise_b |=> flags_ff[`FLAG_PIN_B])
        else $error("pin b flag missing");
    AST_TIMER_SET: assert property (
        reached |=> flags_ff[`FLAG_TIMER])
        else $error("target flag missing");
    AST_W1C_HOST_TX: assert property (
        (wr_en && i_paddr == `ADDR_STATUS_ENABLE && i_pwdata[3] && !i_host_tx_capture)
        |=> !flags_ff[3]) else $error("host transmit flag not cleared");
    AST_ZERO_KEEPS: assert property (
        (wr_en && i_paddr == `ADDR_STATUS_ENABLE && !i_pwdata[8] && flags_ff[8])
        |=> flags_ff[8]) else $error("zero write changed a flag");
    AST_EN_WRITE: assert property (
        (wr_en && i_paddr == `ADDR_STATUS_ENABLE && i_pwdata[24])
        |=> enables_ff[8]) else $error("enable bit not sixteen above its flag");
    AST_SUMMARY_OFF: assert property (
        !(|(flags_ff & enables_ff)) |=> !summary_ff)
        else $error("summary without an enabled flag");
    // system interrupt gate, then pin and register read checks
    AST_IRQ_SET: assert property (
        (|(flags_ff & enables_ff) && chip_en_ff) |=> o_irq)
        else $error("irq missing");
    AST_IRQ_OFF: assert property (
        !chip_en_ff |=> !o_irq)
        else $error("irq with chip enable clear");
    AST_IRQ_SUMMARY: assert property (
        o_irq |-> o_timestamp_summary_event)
        else $error("irq without summary");
    AST_PIN_CLR_A: assert property (
        (rise_a && cfg_ff[`CFG_CLR_A] && !reached) |=> !flags_ff[`FLAG_TIMER])
        else $error("pin a edge did not clear target flag");
    AST_LOAD_FREE: assert property (
        (rise_a && !flags_ff[`FLAG_PIN_A]) |=> o_pin_a_capture_load)
        else $error("unlocked capture dropped");
    AST_TOGGLE_B: assert property (
        (mode_b == PIN_TOGGLE && reached) |=> o_pin_b_out != $past(o_pin_b_out))
        else $error("pin b toggle missing");
    AST_PULSE_A: assert property (
        (mode_a == PIN_PULSE) |=> o_pin_a_out == $past(reached))
        else $error("pin a pulse wrong");
    AST_CHIP_STATUS_READ: assert property (
        (rd_en && i_paddr == `ADDR_CHIP_STATUS)
        |=> o_prdata[`SUMMARY_BIT] == $past(summary_ff))
        else $error("chip status read wrong");
    AST_RSVD_READ: assert property (
        (rd_en && i_paddr == `ADDR_STATUS_ENABLE)
        |=> (o_prdata[31:25] == 7'h00 && o_prdata[15:9] == 7'h00))
        else $error("reserved bits read nonzero");
    // apb answer
    AST_READY_NEXT: assert property (
        (i_psel && i_penable && !o_pready) |=> o_pready)
        else $error("pready late");
    AST_SLVERR: assert property (
        (i_psel && i_penable && !o_pready && !addr_ok) |=> o_pslverr)
        else $error("pslverr missing on unmapped address");
    AST_SLVERR_WITH_READY: assert property (
        o_pslverr |-> o_pready)
        else $error("pslverr without pready");
    COV_LOCKED: cover property (rise_a && cfg_ff[`CFG_LOCK_A] && flags_ff[`FLAG_PIN_A]);
    COV_IRQ: cover property (o_irq);
    COV_CLEAR: cover property (wr_en && i_paddr == `ADDR_STATUS_ENABLE && |i_pwdata[8:0]);
    COV_TIMER_PIN_CLR: cover property (rise_a && cfg_ff[`CFG_CLR_A] && flags_ff[0]);
endmodule
`default_nettype wire

/* File: tb/ptp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ptp_host_model (
    // clock
    input  wire logic        i_clk,
    // apb master side
    output logic             o_psel,
    output logic             o_penable,
    output logic             o_pwrite,
    output logic      [11:0] o_paddr,
    output logic      [31:0] o_pwdata,
    input  wire logic [31:0] i_prdata,
    input  wire logic        i_pready,
    input  wire logic        i_pslverr
);
    initial begin
        o_psel    = 1'b0;
        o_penable = 1'b0;
        o_pwrite  = 1'b0;
        o_paddr   = 12'h000;
        o_pwdata  = 32'h0;
    end
    // waits for the answer however late; only the bench watchdog ends a dead wait
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        @(posedge i_clk);
        o_psel    <= 1'b1;
        o_penable <= 1'b0;
        o_pwrite  <= wr;
        o_paddr   <= a;
        o_pwdata  <= d;
        @(posedge i_clk);
        o_penable <= 1'b1;
        do begin
            @(posedge i_clk);
        end while (i_pready !== 1'b1);
        q = i_prdata;
        err = i_pslverr;
        o_psel    <= 1'b0;
        o_penable <= 1'b0;
        // released data bus must not keep showing the last word
        o_pwdata  <= ~d;
    endtask
endmodule
`default_nettype wire

/* File: tb/ptp_event_interrupt_status_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ptp_event_defines.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module ptp_event_interrupt_status_tb;
    logic        clk, rstn, psel, penable, pwrite, pready, pslverr, err;
    logic        pin_a, pin_b, sum, irq, pa_out, pb_out, load;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, thi, tlo, q, en, ex;
    logic [63:0] cval;
    logic [5:0]  cap;
    int          err_total, n_checks;
    int          n_load = 0;

    ptp_host_model i_host (.i_clk(clk), .o_psel(psel), .o_penable(penable),
        .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata),
        .i_pready(pready), .i_pslverr(pslverr));

    ptp_event_interrupt_status i_dut (.i_clk(clk), .i_rstn(rstn), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_p2_rx_capture(cap[5]), .i_p2_tx_capture(cap[4]), .i_p1_rx_capture(cap[3]),
        .i_p1_tx_capture(cap[2]), .i_host_rx_capture(cap[1]), .i_host_tx_capture(cap[0]),
        .i_pin_a(pin_a), .i_pin_b(pin_b), .i_clock_value(cval),
        .i_target_high_word(thi), .i_target_low_word(tlo),
        .o_timestamp_summary_event(sum), .o_irq(irq), .o_pin_a_out(pa_out),
        .o_pin_b_out(pb_out), .o_pin_a_capture_load(load));

    always #50 clk = ~clk;

    always @(posedge clk) begin
        if (load === 1'b1) n_load <= n_load + 1;
    end

    function automatic logic exp_sum(input logic [31:0] w);
        return |(w[8:0] & w[24:16]);
    endfunction

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        i_host.xfer(1'b1, a, d, q, err);
    endtask

    task automatic rd(input logic [11:0] a);
        i_host.xfer(1'b0, a, 32'h0, q, err);
    endtask

    // one clean rise held a full cycle, well over the minimum active time
    task automatic pulse_pin(input logic b);
        @(posedge clk);
        if (b) pin_b <= 1'b1;
        else pin_a <= 1'b1;
        @(posedge clk);
        pin_a <= 1'b0;
        pin_b <= 1'b0;
        repeat (5) @(posedge clk);
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        complete_run();
    end

    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        cap = 6'h0;
        pin_a = 1'b0;
        pin_b = 1'b0;
        cval = 64'h0;
        err_total = 0;
        n_checks = 0;
        void'($urandom(32'h98f5));
        thi = $urandom | 32'h1;
        tlo = $urandom;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        rd(`ADDR_STATUS_ENABLE);
        `CHK("reset status", 32'h0, q)
        rd(`ADDR_CHIP_ENABLE);
        `CHK("reset chip enable", 32'h0, q)
        repeat (4) begin
            en = $urandom;
            wr(`ADDR_STATUS_ENABLE, en);
            rd(`ADDR_STATUS_ENABLE);
            `CHK("enable readback", en & `EN_MASK, q)
        end
        rd(12'h000);
        `CHK("unmapped error", 1'b1, err)
        `CHK("unmapped data", 32'h0, q)
        // chip gate still closed: summary rises, system interrupt stays low
        wr(`ADDR_STATUS_ENABLE, `EN_MASK);
        @(posedge clk);
        cap <= 6'h20;
        @(posedge clk);
        cap <= 6'h0;
        repeat (4) @(posedge clk);
        `CHK("gated summary", 1'b1, sum)
        `CHK("gated irq", 1'b0, irq)
        wr(`ADDR_STATUS_ENABLE, `EN_MASK);
        rd(`ADDR_STATUS_ENABLE);
        `CHK("zero write keeps flag", `EN_MASK | 32'h100, q)
        wr(`ADDR_STATUS_ENABLE, `FLAG_MASK);
        rd(`ADDR_STATUS_ENABLE);
        `CHK("all flags cleared", 32'h0, q)
        wr(`ADDR_CHIP_ENABLE, 32'h2000_0000);
        // all enables, none, then random sets
        for (int i = 0; i < 6; i++) begin
            en = (i == 0) ? `EN_MASK : (i == 1) ? 32'h0 : $urandom & `EN_MASK;
            wr(`ADDR_STATUS_ENABLE, en);
            @(posedge clk);
            cap <= 6'h1 << i;
            @(posedge clk);
            cap <= 6'h0;
            repeat (4) @(posedge clk);
            ex = en | (32'h1 << (i + 3));
            `CHK("summary", exp_sum(ex), sum)
            `CHK("irq", exp_sum(ex), irq)
            rd(`ADDR_STATUS_ENABLE);
            `CHK("capture flag", ex, q)
            rd(`ADDR_CHIP_STATUS);
            `CHK("chip status", {2'b0, exp_sum(ex), 29'h0}, q)
            wr(`ADDR_STATUS_ENABLE, ex);
            rd(`ADDR_STATUS_ENABLE);
            `CHK("flag cleared", en, q)
        end
        pulse_pin(1'b1);
        rd(`ADDR_STATUS_ENABLE);
        `CHK("pin b flag", en | 32'h4, q)
        wr(`ADDR_STATUS_ENABLE, en | 32'h4);
        // pin a: level mode, lock, clears target flag; pin b toggles on target
        wr(`ADDR_PIN_CONFIG, 32'h6c);
        cval <= {thi, tlo} - 64'h1;
        repeat (3) @(posedge clk);
        rd(`ADDR_STATUS_ENABLE);
        `CHK("below target", en, q)
        cval <= {thi, tlo};
        repeat (3) @(posedge clk);
        rd(`ADDR_STATUS_ENABLE);
        `CHK("target flag", en | 32'h1, q)
        `CHK("pin a level", 1'b1, pa_out)
        `CHK("pin b toggled", 1'b1, pb_out)
        pulse_pin(1'b0);
        rd(`ADDR_STATUS_ENABLE);
        `CHK("pin a clears target", en | 32'h2, q)
        `CHK("pin a level low", 1'b0, pa_out)
        `CHK("pin b toggle holds", 1'b1, pb_out)
        pulse_pin(1'b0);
        `CHK("locked loads", 1, n_load)
        complete_run();
    end
endmodule
`default_nettype wire
